// ===== hw/psr_relay_bank.sv
// Special relay bank: timing pulses, clock control, flags, interrupt gating
module psr_relay_bank
	import psr_pkg::*;
#(
	parameter int MS_CYC = MS_CYCLES
)
(
	input  wire  logic        mclk,
	input  wire  logic        rst_n,
	input  wire  logic [7:0]  addr,
	input  wire  logic [15:0] wdata,
	input  wire  logic        wr,
	input  wire  logic        rd,
	output logic [15:0]       rdata,
	input  wire  logic        run_mode,
	input  wire  psr_alu_ev_s alu_ev,
	input  wire  logic        instr_done_evt,
	input  wire  logic        global_irq_enable_instr,
	input  wire  logic        global_irq_disable_instr,
	input  wire  logic        module_io_busy,
	input  wire  logic [8:0]  irq_req,
	input  wire  logic        rtc_error,
	output logic              pulse_10ms_bit,
	output logic              pulse_100ms_bit,
	output logic              pulse_1s_bit,
	output logic              pulse_1min_bit,
	output logic              clock_halt_preset_ctl,
	output logic              time_display_freeze_ctl,
	output logic              seconds_adjust_ctl,
	output logic              block_move_direction_bit,
	output logic              irq_dispatch,
	output logic [3:0]        irq_dispatch_id
);

	//--------------------------------------------------------------------------
	// State
	//--------------------------------------------------------------------------
	typedef struct packed {
		logic [16:0] ms_cnt;
		logic [15:0] c10;
		logic [15:0] c100;
		logic [15:0] c1s;
		logic [15:0] c1m;
		logic        p10;
		logic        p100;
		logic        p1s;
		logic        p1m;
		logic        halt;
		logic        freeze;
		logic        adj;
		logic        fault;
		logic        zero;
		logic        borrow;
		logic        carry;
		logic        dir;
		logic        permit;
		logic        done;
		logic [8:0]  dis;
		logic [8:0]  pend;
		logic        gie;
		logic        run_q;
		logic        go;
		logic [3:0]  go_id;
		logic [15:0] rdata;
	} psr_state_s;

	psr_state_s state_reg;
	psr_state_s state_next;

	//--------------------------------------------------------------------------
	// Helpers
	//--------------------------------------------------------------------------
	// Returns {wrap, next count} for a half-period counter in milliseconds
	function automatic logic [16:0] psr_half(
		input logic [15:0] cnt,
		input logic [15:0] half
	);
		if (cnt == half - 16'h0001)
			psr_half = {1'b1, 16'h0000};
		else
			psr_half = {1'b0, cnt + 16'h0001};
	endfunction

	// Lowest numbered set bit; the fixed order keeps input sources ahead
	function automatic logic [3:0] psr_first(
		input logic [8:0] v
	);
		psr_first = 4'h0;
		for (int i = IRQ_SOURCES - 1; i >= 0; i--)
			if (v[i])
				psr_first = 4'(i);
	endfunction

	//--------------------------------------------------------------------------
	// Next state
	//--------------------------------------------------------------------------
	logic        ms_tick;
	logic [16:0] h10;
	logic [16:0] h100;
	logic [16:0] h1s;
	logic [16:0] h1m;
	logic [8:0]  ready;
	logic        may_run;
	logic [3:0]  pick;
	logic [8:0]  clr;

	always_comb
	begin
		state_next = state_reg;
		state_next.adj = 1'b0;
		state_next.go = 1'b0;

		// One shared millisecond tick keeps every pulse edge aligned
		ms_tick = (state_reg.ms_cnt == 17'(MS_CYC - 1));
		state_next.ms_cnt = ms_tick ? 17'h00000
			: state_reg.ms_cnt + 17'h00001;
		h10  = psr_half(state_reg.c10, HALF_10MS_MS);
		h100 = psr_half(state_reg.c100, HALF_100MS_MS);
		h1s  = psr_half(state_reg.c1s, HALF_1S_MS);
		h1m  = psr_half(state_reg.c1m, HALF_1MIN_MS);
		if (ms_tick)
		begin
			state_next.c10  = h10[15:0];
			state_next.c100 = h100[15:0];
			state_next.c1s  = h1s[15:0];
			state_next.c1m  = h1m[15:0];
			state_next.p10  = state_reg.p10 ^ h10[16];
			state_next.p100 = state_reg.p100 ^ h100[16];
			state_next.p1s  = state_reg.p1s ^ h1s[16];
			state_next.p1m  = state_reg.p1m ^ h1m[16];
		end

		state_next.fault = rtc_error;

		// Software writes first, so hardware events below win a collision
		if (wr)
		begin
			case (addr)
				REG_RTC:
				begin
					state_next.halt   = wdata[RTC_HALT_BIT];
					state_next.freeze = wdata[RTC_FREEZE_BIT];
					state_next.adj    = wdata[RTC_ADJ_BIT];
				end
				REG_FLAG:
				begin
					state_next.zero   = wdata[FLG_ZERO_BIT];
					state_next.borrow = wdata[FLG_BORROW_BIT];
					state_next.carry  = wdata[FLG_CARRY_BIT];
					state_next.dir    = wdata[FLG_DIR_BIT];
					state_next.permit = wdata[FLG_PERMIT_BIT];
					state_next.done   = wdata[FLG_DONE_BIT];
				end
				REG_IRQ_DIS:
					state_next.dis = wdata[8:0];
				default:
					state_next.dis = state_reg.dis;
			endcase
		end

		// Arithmetic flags
		if (alu_ev.valid)
		begin
			case (alu_ev.op)
				ALU_ADD:
				begin
					state_next.zero  = alu_ev.result_zero;
					state_next.carry = alu_ev.carry_out;
				end
				ALU_SUB:
				begin
					state_next.zero   = alu_ev.result_zero;
					state_next.borrow = alu_ev.underflow;
				end
				ALU_SHIFT:
					state_next.carry = alu_ev.carry_out;
				default:
					state_next.zero = state_next.zero;
			endcase
		end
		if (instr_done_evt)
			state_next.done = 1'b1;

		// Leaving RUN for STOP drops the move direction
		state_next.run_q = run_mode;
		if (state_reg.run_q && !run_mode)
			state_next.dir = 1'b0;

		// Global enable: a disable in the same cycle wins
		if (global_irq_enable_instr)
			state_next.gie = 1'b1;
		if (global_irq_disable_instr)
			state_next.gie = 1'b0;

		// Dispatch one pending source per cycle while allowed
		ready = state_reg.pend & ~state_reg.dis;
		may_run = state_reg.gie
			&& !(module_io_busy && !state_reg.permit)
			&& (ready != 9'h000);
		pick = psr_first(ready);
		clr = may_run ? (9'h001 << pick) : 9'h000;
		state_next.go = may_run;
		state_next.go_id = may_run ? pick : state_reg.go_id;
		// New requests are ORed after the clear so none is lost
		state_next.pend = (state_reg.pend & ~clr)
			| (irq_req & ~state_reg.dis);

		// Read data stand only in the cycle after the strobe
		state_next.rdata = 16'h0000;
		if (rd)
		begin
			case (addr)
				REG_PULSE:
					state_next.rdata = {12'h000, state_reg.p1m,
						state_reg.p1s, state_reg.p100, state_reg.p10};
				REG_RTC:
					state_next.rdata = {11'h000, state_reg.fault,
						1'b1, 1'b0, state_reg.freeze,
						state_reg.halt};
				REG_FLAG:
					state_next.rdata = {10'h000, state_reg.done,
						state_reg.permit, state_reg.dir,
						state_reg.carry, state_reg.borrow,
						state_reg.zero};
				REG_IRQ_DIS:
					state_next.rdata = {7'h00, state_reg.dis};
				REG_IRQ_PEND:
					state_next.rdata = {7'h00, state_reg.pend};
				REG_IRQ_CTL:
					state_next.rdata = {15'h0000, state_reg.gie};
				default:
					state_next.rdata = 16'h0000;
			endcase
		end
	end

	//--------------------------------------------------------------------------
	// Registers
	//--------------------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= '0;
			state_reg.dis <= IRQ_DIS_RST;
		end
		else
			state_reg <= state_next;
	end

	//--------------------------------------------------------------------------
	// Outputs
	//--------------------------------------------------------------------------
	assign rdata                    = state_reg.rdata;
	assign pulse_10ms_bit           = state_reg.p10;
	assign pulse_100ms_bit          = state_reg.p100;
	assign pulse_1s_bit             = state_reg.p1s;
	assign pulse_1min_bit           = state_reg.p1m;
	assign clock_halt_preset_ctl    = state_reg.halt;
	assign time_display_freeze_ctl  = state_reg.freeze;
	assign seconds_adjust_ctl       = state_reg.adj;
	assign block_move_direction_bit = state_reg.dir;
	assign irq_dispatch             = state_reg.go;
	assign irq_dispatch_id          = state_reg.go_id;

endmodule // psr_relay_bank

// ===== hw/psr_pkg.sv
// Constants, field layout and carrier types of the special relay bank
//------------------------------------------------------------------------------
// Overview of operation
// - Fast pulse bit runs with a 10 ms period, 5 ms high, 5 ms low.
// - Tenth-second pulse bit runs with a 100 ms period, 50 ms each half.
// - One-second pulse bit runs with a 1 s period, 500 ms each half.
// - One-minute pulse bit runs with a 1 min period, 30 s each half.
// - Clock halt bit stops the real-time clock so a new time can be preset.
// - Display freeze bit stops updating of the time values presented for reading.
// - Seconds adjust bit applies a plus or minus 30 s correction to the clock.
// - Clock present status always reads as set.
// - Clock fault status is set while the real-time clock reports an error.
// - Zero flag follows whether an add or subtract result is zero.
// - Borrow flag sets when a subtract falls below the smallest negative number.
// - Carry flag sets on an add carry or a shift overflow.
// - Direction bit steers block move copies; cleared when leaving RUN for STOP.
// - Interrupts during module read/write instructions only when permit bit set.
// - Done flag sets once an operation such as a switch read completes.
// - Nine disable bits: six input interrupts, three timer interrupts, one each.
// - A request whose disable bit is set never runs its routine.
// - A request whose disable bit is clear is accepted and held pending.
// - Accepted requests dispatch at once while the global enable is in effect.
// - While globally disabled, accepted requests wait until enabled again.
//------------------------------------------------------------------------------
package psr_pkg;

	//--------------------------------------------------------------------------
	// Timing
	//--------------------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 8000;
	localparam int TIMEBASE_PS   = 1000000000;
	localparam int MS_CYCLES     = TIMEBASE_PS / CLK_PERIOD_PS;
	localparam logic [15:0] HALF_10MS_MS  = 16'h0005;
	localparam logic [15:0] HALF_100MS_MS = 16'h0032;
	localparam logic [15:0] HALF_1S_MS    = 16'h01f4;
	localparam logic [15:0] HALF_1MIN_MS  = 16'h7530;

	//--------------------------------------------------------------------------
	// Register offsets
	//--------------------------------------------------------------------------
	localparam logic [7:0] REG_PULSE    = 8'h00;
	localparam logic [7:0] REG_RTC      = 8'h01;
	localparam logic [7:0] REG_FLAG     = 8'h02;
	localparam logic [7:0] REG_IRQ_DIS  = 8'h03;
	localparam logic [7:0] REG_IRQ_PEND = 8'h04;
	localparam logic [7:0] REG_IRQ_CTL  = 8'h05;

	//--------------------------------------------------------------------------
	// Field positions
	//--------------------------------------------------------------------------
	localparam int RTC_HALT_BIT    = 0;
	localparam int RTC_FREEZE_BIT  = 1;
	localparam int RTC_ADJ_BIT     = 2;
	localparam int RTC_PRESENT_BIT = 3;
	localparam int RTC_FAULT_BIT   = 4;
	localparam int FLG_ZERO_BIT    = 0;
	localparam int FLG_BORROW_BIT  = 1;
	localparam int FLG_CARRY_BIT   = 2;
	localparam int FLG_DIR_BIT     = 3;
	localparam int FLG_PERMIT_BIT  = 4;
	localparam int FLG_DONE_BIT    = 5;
	localparam int IRQ_SOURCES     = 9;

	//--------------------------------------------------------------------------
	// Reset values
	//--------------------------------------------------------------------------
	localparam logic [8:0] IRQ_DIS_RST = 9'h000;

	//--------------------------------------------------------------------------
	// Carrier types
	//--------------------------------------------------------------------------
	typedef enum logic [1:0] {
		ALU_NONE  = 2'h0,
		ALU_ADD   = 2'h1,
		ALU_SUB   = 2'h3,
		ALU_SHIFT = 2'h2
	} psr_alu_op_e;

	typedef struct packed {
		logic        valid;
		psr_alu_op_e op;
		logic        result_zero;
		logic        carry_out;
		logic        underflow;
	} psr_alu_ev_s;

endpackage

// ===== dv/psr_relay_bank_chk.sv
// Port checker for the special relay bank
module psr_relay_bank_chk
	import psr_pkg::*;
#(
	parameter int MS_CYC = 1
)
(
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic [7:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [15:0] rdata,
	input wire logic        run_mode,
	input wire logic        pulse_10ms_bit,
	input wire logic        pulse_100ms_bit,
	input wire logic        pulse_1s_bit,
	input wire logic        pulse_1min_bit,
	input wire logic        clock_halt_preset_ctl,
	input wire logic        time_display_freeze_ctl,
	input wire logic        seconds_adjust_ctl,
	input wire logic        block_move_direction_bit
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int H0 = int'(HALF_10MS_MS) * MS_CYC;
	localparam int H1 = int'(HALF_100MS_MS) * MS_CYC;
	localparam int H2 = int'(HALF_1S_MS) * MS_CYC;
	localparam int H3 = int'(HALF_1MIN_MS) * MS_CYC;
	logic [3:0]  p;
	logic [3:0]  pq;
	logic [3:0]  seen;
	logic [31:0] cnt [4];
	assign p = {pulse_1min_bit, pulse_1s_bit, pulse_100ms_bit, pulse_10ms_bit};

	//--------------------------------------------------------------------------
	// Half-period counters
	//--------------------------------------------------------------------------
	// The first half after reset is not judged: its start depends on release
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pq   <= '0;
			seen <= '0;
			cnt  <= '{default: '0};
		end
		else
		begin
			pq <= p;
			for (int i = 0; i < 4; i++)
			begin
				if (p[i] != pq[i])
				begin
					cnt[i]  <= 32'h1;
					seen[i] <= 1'b1;
				end
				else
					cnt[i] <= cnt[i] + 32'h1;
			end
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_rtc_wr;
		wr && addr == REG_RTC;
	endsequence

	a_halt_follow : assert property (
		s_rtc_wr |=> clock_halt_preset_ctl == $past(wdata[RTC_HALT_BIT]))
		else $error("halt bit mismatch");
	a_freeze_follow : assert property (
		s_rtc_wr |=> time_display_freeze_ctl == $past(wdata[RTC_FREEZE_BIT]))
		else $error("freeze bit mismatch");
	a_adjust_pulse : assert property (
		s_rtc_wr ##0 wdata[RTC_ADJ_BIT] |=> seconds_adjust_ctl)
		else $error("adjust pulse missing");
	a_present_read : assert property (
		rd && addr == REG_RTC |=> rdata[RTC_PRESENT_BIT])
		else $error("present bit low");
	a_dir_stop : assert property (
		$fell(run_mode) |-> ##[1:2] !block_move_direction_bit)
		else $error("direction kept on stop");
	a_pulse_10ms : assert property (
		seen[0] && p[0] != pq[0] |-> cnt[0] == H0)
		else $error("10ms half period wrong");
	a_pulse_100ms : assert property (
		seen[1] && p[1] != pq[1] |-> cnt[1] == H1)
		else $error("100ms half period wrong");
	a_pulse_1s : assert property (
		seen[2] && p[2] != pq[2] |-> cnt[2] == H2)
		else $error("1s half period wrong");
	a_pulse_1min : assert property (
		seen[3] && p[3] != pq[3] |-> cnt[3] == H3)
		else $error("1min half period wrong");
	a_pulse_align : assert property (
		p[2] != pq[2] |-> (p[1:0] ^ pq[1:0]) == 2'b11)
		else $error("pulse edges not aligned");
endmodule // psr_relay_bank_chk

bind psr_relay_bank psr_relay_bank_chk #(.MS_CYC(MS_CYC)) u_chk (
	.mclk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .run_mode,
	.pulse_10ms_bit, .pulse_100ms_bit, .pulse_1s_bit, .pulse_1min_bit,
	.clock_halt_preset_ctl, .time_display_freeze_ctl, .seconds_adjust_ctl,
	.block_move_direction_bit);

// ===== dv/psr_relay_bank_test.sv
// Self-checking bench for the special relay bank
module psr_relay_bank_test
	import psr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, rst_n, wr, rd, run_mode, instr_done_evt;
	logic        global_irq_enable_instr, global_irq_disable_instr;
	logic        module_io_busy, rtc_error, irq_dispatch;
	logic        pulse_10ms_bit, pulse_100ms_bit, pulse_1s_bit;
	logic        pulse_1min_bit, clock_halt_preset_ctl;
	logic        time_display_freeze_ctl, seconds_adjust_ctl;
	logic        block_move_direction_bit;
	logic [7:0]  addr;
	logic [15:0] wdata, rdata;
	logic [8:0]  irq_req;
	logic [3:0]  irq_dispatch_id;
	psr_alu_ev_s alu_ev;
	int          bad_count = 0;
	int          checks = 0;

	psr_relay_bank #(.MS_CYC(1)) u_dut (.mclk, .rst_n, .addr, .wdata, .wr,
		.rd, .rdata, .run_mode, .alu_ev, .instr_done_evt,
		.global_irq_enable_instr, .global_irq_disable_instr,
		.module_io_busy, .irq_req, .rtc_error, .pulse_10ms_bit,
		.pulse_100ms_bit, .pulse_1s_bit, .pulse_1min_bit,
		.clock_halt_preset_ctl, .time_display_freeze_ctl,
		.seconds_adjust_ctl, .block_move_direction_bit, .irq_dispatch,
		.irq_dispatch_id);

	initial
	begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	task automatic cmp(input string w, input logic [15:0] exp, got);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("BAD %s expected %h seen %h", w, exp, got);
		end
	endtask

	task automatic tally_and_finish();
		if (bad_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input string w, input logic [7:0] a,
		input logic [15:0] exp);
		@(posedge mclk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		@(negedge mclk);
		cmp(w, exp, rdata);
	endtask

	task automatic alu(input psr_alu_op_e op, input logic z, c, u);
		@(posedge mclk);
		alu_ev <= '{1'b1, op, z, c, u};
		@(posedge mclk);
		alu_ev <= '0;
	endtask

	task automatic gie(input logic en);
		@(posedge mclk);
		global_irq_enable_instr  <= en;
		global_irq_disable_instr <= !en;
		@(posedge mclk);
		global_irq_enable_instr  <= 1'b0;
		global_irq_disable_instr <= 1'b0;
	endtask

	// Request is sampled at the second edge, dispatch shows one edge later
	task automatic fire(input int i, input logic hit);
		@(posedge mclk);
		irq_req <= 9'h001 << i;
		@(posedge mclk);
		irq_req <= '0;
		@(posedge mclk);
		@(negedge mclk);
		cmp("dispatch", 16'(hit), 16'(irq_dispatch));
		if (hit)
			cmp("dispatch_id", 16'(i), 16'(irq_dispatch_id));
	endtask

	task automatic catch_irq(input logic [3:0] id);
		int n;
		n = 0;
		while (irq_dispatch !== 1'b1 && n < 8)
		begin
			@(negedge mclk);
			n++;
		end
		cmp("late_dispatch", 16'h0001, 16'(irq_dispatch));
		cmp("late_id", 16'(id), 16'(irq_dispatch_id));
	endtask

	task automatic t_rtc();
		rd_chk("rtc_reset", REG_RTC, 16'h0008);
		rd_chk("unmapped", 8'h40, 16'h0000);
		rd_chk("dis_reset", REG_IRQ_DIS, 16'(IRQ_DIS_RST));
		wr_reg(REG_RTC, 16'h0003);
		@(negedge mclk);
		cmp("halt", 16'h0001, 16'(clock_halt_preset_ctl));
		cmp("freeze", 16'h0001, 16'(time_display_freeze_ctl));
		@(posedge mclk);
		rtc_error <= 1'b1;
		rd_chk("rtc_fault", REG_RTC, 16'h001b);
		wr_reg(REG_RTC, 16'h0004);
		@(negedge mclk);
		cmp("adjust", 16'h0001, 16'(seconds_adjust_ctl));
		@(negedge mclk);
		cmp("adjust_end", 16'h0000, 16'(seconds_adjust_ctl));
		rd_chk("rtc_clear", REG_RTC, 16'h0018);
		@(posedge mclk);
		rtc_error <= 1'b0;
	endtask

	task automatic t_flags();
		alu(ALU_ADD, 1'b1, 1'b1, 1'b0);
		rd_chk("add", REG_FLAG, 16'h0005);
		alu(ALU_SUB, 1'b0, 1'b0, 1'b1);
		rd_chk("sub", REG_FLAG, 16'h0006);
		alu(ALU_ADD, 1'b0, 1'b0, 1'b0);
		rd_chk("add_clear", REG_FLAG, 16'h0002);
		alu(ALU_SHIFT, 1'b0, 1'b1, 1'b0);
		rd_chk("shift", REG_FLAG, 16'h0006);
		@(posedge mclk);
		instr_done_evt <= 1'b1;
		@(posedge mclk);
		instr_done_evt <= 1'b0;
		rd_chk("done", REG_FLAG, 16'h0026);
		wr_reg(REG_FLAG, 16'h0008);
		@(negedge mclk);
		cmp("dir", 16'h0001, 16'(block_move_direction_bit));
		@(posedge mclk);
		run_mode <= 1'b0;
		repeat (3) @(posedge mclk);
		run_mode <= 1'b1;
		rd_chk("dir_stop", REG_FLAG, 16'h0000);
	endtask

	task automatic t_irq();
		gie(1'b1);
		for (int i = 0; i < IRQ_SOURCES; i++)
		begin
			wr_reg(REG_IRQ_DIS, 16'h01ff ^ (16'h0001 << i));
			fire(i, 1'b1);
			wr_reg(REG_IRQ_DIS, 16'h0001 << i);
			fire(i, 1'b0);
			rd_chk("dropped", REG_IRQ_PEND, 16'h0000);
		end
		wr_reg(REG_IRQ_DIS, 16'h0000);
		gie(1'b0);
		rd_chk("gie_off", REG_IRQ_CTL, 16'h0000);
		fire(2, 1'b0);
		rd_chk("held", REG_IRQ_PEND, 16'h0004);
		gie(1'b1);
		catch_irq(4'h2);
		@(posedge mclk);
		module_io_busy <= 1'b1;
		fire(4, 1'b0);
		wr_reg(REG_FLAG, 16'h0010);
		catch_irq(4'h4);
		@(posedge mclk);
		module_io_busy <= 1'b0;
	endtask

	initial
	begin
		{wr, rd, instr_done_evt, global_irq_enable_instr,
			global_irq_disable_instr, module_io_busy, rtc_error} = '0;
		addr = '0;
		wdata = '0;
		irq_req = '0;
		alu_ev = '0;
		run_mode = 1'b1;
		rst_n = 1'b0;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		t_rtc();
		t_flags();
		t_irq();
		// Idle long enough for two halves of the slowest pulse
		repeat (61000) @(posedge mclk);
		tally_and_finish();
	end

	initial
	begin
		#560000;
		bad_count++;
		tally_and_finish();
	end
endmodule // psr_relay_bank_test
